// ---- src/srfd_params.svh ----
// Constants for the serial receive frame decoder
`ifndef SRFD_PARAMS_SVH
`define SRFD_PARAMS_SVH

// ----------------------------------------
// Symbol timing, counted in bit times
// ----------------------------------------
`define SRFD_BIT_FIRST 4'h0
`define SRFD_BIT_LAST 4'h9
`define SRFD_RDY_LOW_BITS 4'h6
`define SRFD_BCLK_HIGH_BITS 4'h5

// ----------------------------------------
// Comma symbols, bit a in the msb
// ----------------------------------------
`define SRFD_K285_NEG 10'h0fa
`define SRFD_K285_POS 10'h305
`define SRFD_K28_POS6 6'h30

// ----------------------------------------
// Output codes
// ----------------------------------------
`define SRFD_CODE_K281 8'h01
`define SRFD_CODE_K285 8'h05
`define SRFD_CODE_K287 8'h07
`define SRFD_CODE_K237 8'h08
`define SRFD_CODE_K277 8'h09
`define SRFD_CODE_K297 8'h0a
`define SRFD_CODE_K307 8'h0b
`define SRFD_CODE_C71 8'h27
`define SRFD_CODE_C72 8'h47
`define SRFD_CODE_BAD 8'he0
`define SRFD_CODE_K285_RDP 8'he1
`define SRFD_CODE_K285_RDN 8'he2
`define SRFD_CODE_RD_ERR 8'he4

// ----------------------------------------
// Register map
// ----------------------------------------
`define SRFD_ADR_W 4
`define SRFD_REG_CTRL 4'h0
`define SRFD_REG_STATUS 4'h4
`define SRFD_CTRL_MSB 2
`define SRFD_CTRL_RST 3'h4
`define SRFD_ST_AWAIT_BIT 0
`define SRFD_ST_RD_BIT 1
`define SRFD_ST_WORD_LSB 4
`define SRFD_ST_WORD_MSB 13

`endif

// ---- src/srfd_pkg.sv ----
// Types for the serial receive frame decoder
package srfd_pkg;
  typedef enum logic [1:0] {SRFD_ENCODED, SRFD_BYPASS, SRFD_TEST} srfd_mode_e;
  typedef struct packed {
    logic violation;
    logic special;
    logic [7:0] data;
  } srfd_word_s;
  typedef struct packed {
    logic rf;
    srfd_mode_e mode;
  } srfd_ctrl_s;
endpackage

// ---- src/srfd_rx.sv ----
// Serial receiver: deserializer, comma framer, 8b/10b decoder and ready strobe
`timescale 1ns/1ns
`include "srfd_params.svh"

// Overview of operation
// [RULE1] Shift bits on recovered bit clock; move symbol to decode register every ten bits.
// [RULE2] A K28.5 comma resets the bit counter, aligning symbols to byte boundaries.
// [RULE3] With reframe disabled the framer never resynchronises the bit counter.
// [RULE4] After reframe rises, ready stays inhibited until a K28.5 is found.
// [RULE5] Data keeps flowing to the outputs while ready is inhibited.
// [RULE6] Encoded mode gives eight data bits, a special flag and a violation flag.
// [RULE7] A deliberately sent violation symbol decodes like a link error, code C0.7.
// [RULE8] Bypass mode moves the decode register unchanged to the 10-bit output.
// [RULE9] Comma framing works in bypass mode just as in encoded mode.
// [RULE10] All ten outputs change together, aligned with ready and byte clock.
// [RULE11] Ready is an active-low byte-rate pulse, low for 60 percent of a byte.
// [RULE12] Ready stays high on fill characters; receiver ignores data while ready is high.
// [RULE13] K28.5 followed by K28.5 is fill: no ready pulse, output stays 05 special.
// [RULE14] K28.5 followed by anything else is data and gets a ready pulse.
// [RULE15] Bypass mode with reframe enabled pulses ready once per K28.5.
// [RULE16] Good data code with good disparity: violation 0, special 0, byte 00-FF.
// [RULE17] Good special code with good disparity: violation 0, special 1, code 00-0B.
// [RULE18] K28.7 after K28.1 gives 27; after K28.5 gives 47; no violation.
// [RULE19] Unassigned code gives violation 1, special 1, value E0.
// [RULE20] K28.5 of wrong disparity form gives E1 or E2 with both flags set.
// [RULE21] Valid code with wrong running disparity gives both flags set and E4.
// [RULE22] Mode selects bypass, encoded, or test operation.
// [RULE23] Running disparity is tracked across symbols and updated after each character in encoded and test modes, not in bypass.
// [RULE24] After reset the counter free-runs and data is unframed until a comma.
module srfd_rx #(
  parameter logic [3:0] RDY_LOW_BITS = `SRFD_RDY_LOW_BITS // Bit times ready stays low
) (
  input wire logic sys_clk_in, // System clock, 100 MHz
  input wire logic sys_rst_in, // Synchronous reset, active high
  input wire logic rx_bit_clk_in, // Recovered bit clock, asynchronous
  input wire logic rx_serial_in, // Serial data, asynchronous
  input wire logic wb_cyc_in, // Wishbone cycle
  input wire logic wb_stb_in, // Wishbone strobe
  input wire logic wb_we_in, // Wishbone write enable
  input wire logic [`SRFD_ADR_W-1:0] wb_adr_in, // Wishbone byte address
  input wire logic [3:0] wb_sel_in, // Wishbone byte selects
  input wire logic [31:0] wb_dat_in, // Wishbone write data
  output logic [31:0] wb_dat_out, // Wishbone read data
  output logic wb_ack_out, // Wishbone acknowledge
  output logic [7:0] decoded_byte_out, // Decoded byte
  output logic special_char_flag_out, // Special character flag
  output logic violation_flag_out, // Violation flag
  output logic [9:0] raw_symbol_out, // Output register; bypass mode puts bit a in msb, encoded and test modes the violation flag
  output logic ready_n_out, // New byte strobe, active low
  output logic recovered_byte_clock_out // Byte-rate clock
);

  // ----------------------------------------
  // Parameter check
  // ----------------------------------------
  if (RDY_LOW_BITS == 4'h0 || RDY_LOW_BITS > `SRFD_BIT_LAST) begin : g_bad_rdy
    $error("RDY_LOW_BITS must lie between 1 and 9");
  end

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [2:0] bclk_sync_q;
  logic [1:0] sdat_sync_q;
  logic bit_edge;
  logic [9:0] shift_q;
  logic [9:0] shift_d;
  logic [3:0] bit_cnt_q;
  logic [9:0] decode_q;
  logic comma_hit;
  logic boundary;
  srfd_pkg::srfd_word_s out_q;
  srfd_pkg::srfd_word_s dec_word;
  srfd_pkg::srfd_ctrl_s ctrl_q;
  logic bypass;
  logic rd_q;
  logic rd_d;
  logic prev_k281_q;
  logic prev_k285_q;
  logic cur_k281;
  logic cur_k285;
  logic dec_bad;
  logic rf_prev_q;
  logic rf_rise;
  logic await_q;
  logic rdy_arm_q;
  logic fill;
  logic ready_n_q;
  logic byte_clk_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic req;
  logic [6:0] d6;
  logic [4:0] d4;
  logic [3:0] c4;
  logic [1:0] b6;
  logic [1:0] b4;
  logic kx7;

  // ----------------------------------------
  // Code tables
  // ----------------------------------------
  // Returns valid, K28 marker, five-bit value
  function automatic logic [6:0] dec6(input logic [5:0] c);
    case (c)
      6'b100111, 6'b011000: dec6 = {2'b10, 5'd0};
      6'b011101, 6'b100010: dec6 = {2'b10, 5'd1};
      6'b101101, 6'b010010: dec6 = {2'b10, 5'd2};
      6'b110001: dec6 = {2'b10, 5'd3};
      6'b110101, 6'b001010: dec6 = {2'b10, 5'd4};
      6'b101001: dec6 = {2'b10, 5'd5};
      6'b011001: dec6 = {2'b10, 5'd6};
      6'b111000, 6'b000111: dec6 = {2'b10, 5'd7};
      6'b111001, 6'b000110: dec6 = {2'b10, 5'd8};
      6'b100101: dec6 = {2'b10, 5'd9};
      6'b010101: dec6 = {2'b10, 5'd10};
      6'b110100: dec6 = {2'b10, 5'd11};
      6'b001101: dec6 = {2'b10, 5'd12};
      6'b101100: dec6 = {2'b10, 5'd13};
      6'b011100: dec6 = {2'b10, 5'd14};
      6'b010111, 6'b101000: dec6 = {2'b10, 5'd15};
      6'b011011, 6'b100100: dec6 = {2'b10, 5'd16};
      6'b100011: dec6 = {2'b10, 5'd17};
      6'b010011: dec6 = {2'b10, 5'd18};
      6'b110010: dec6 = {2'b10, 5'd19};
      6'b001011: dec6 = {2'b10, 5'd20};
      6'b101010: dec6 = {2'b10, 5'd21};
      6'b011010: dec6 = {2'b10, 5'd22};
      6'b111010, 6'b000101: dec6 = {2'b10, 5'd23};
      6'b110011, 6'b001100: dec6 = {2'b10, 5'd24};
      6'b100110: dec6 = {2'b10, 5'd25};
      6'b010110: dec6 = {2'b10, 5'd26};
      6'b110110, 6'b001001: dec6 = {2'b10, 5'd27};
      6'b001110: dec6 = {2'b10, 5'd28};
      6'b101110, 6'b010001: dec6 = {2'b10, 5'd29};
      6'b011110, 6'b100001: dec6 = {2'b10, 5'd30};
      6'b101011, 6'b010100: dec6 = {2'b10, 5'd31};
      6'b001111, 6'b110000: dec6 = {2'b11, 5'd28};
      default: dec6 = 7'h00;
    endcase
  endfunction

  // Returns valid, alternate x.7 marker, three-bit value
  function automatic logic [4:0] dec4(input logic [3:0] c);
    case (c)
      4'b1011, 4'b0100: dec4 = {2'b10, 3'd0};
      4'b1001: dec4 = {2'b10, 3'd1};
      4'b0101: dec4 = {2'b10, 3'd2};
      4'b1100, 4'b0011: dec4 = {2'b10, 3'd3};
      4'b1101, 4'b0010: dec4 = {2'b10, 3'd4};
      4'b1010: dec4 = {2'b10, 3'd5};
      4'b0110: dec4 = {2'b10, 3'd6};
      4'b1110, 4'b0001: dec4 = {2'b10, 3'd7};
      4'b0111, 4'b1000: dec4 = {2'b11, 3'd7};
      default: dec4 = 5'h00;
    endcase
  endfunction

  // Sub-block disparity: returns error, disparity after the block
  function automatic logic [1:0] blk(input logic [5:0] c, input logic [2:0] half, input logic rd);
    logic [2:0] ones;
    ones = 3'($countones(c));
    if (ones > half) begin
      blk = {rd, 1'b1};
    end else if (ones < half) begin
      blk = {~rd, 1'b0};
    end else if (c == 6'b111000 || c == 6'b001100) begin
      blk = {rd, 1'b0};
    end else if (c == 6'b000111 || c == 6'b000011) begin
      blk = {~rd, 1'b1};
    end else begin
      blk = {1'b0, rd};
    end
  endfunction

  function automatic logic is_comma(input logic [9:0] s);
    is_comma = (s == `SRFD_K285_NEG) || (s == `SRFD_K285_POS);
  endfunction

  // ----------------------------------------
  // Pin synchronisers and deserializer
  // ----------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      bclk_sync_q <= 3'h0;
      sdat_sync_q <= 2'h0;
    end else begin
      bclk_sync_q <= {bclk_sync_q[1:0], rx_bit_clk_in};
      sdat_sync_q <= {sdat_sync_q[0], rx_serial_in};
    end
  end

  assign bit_edge = bclk_sync_q[1] & ~bclk_sync_q[2];
  assign shift_d = {shift_q[8:0], sdat_sync_q[1]};
  assign comma_hit = ctrl_q.rf && is_comma(shift_d); // [RULE2] [RULE3] [RULE9]
  assign boundary = bit_edge && (bit_cnt_q == `SRFD_BIT_LAST || comma_hit); // [RULE1]
  assign bypass = (ctrl_q.mode == srfd_pkg::SRFD_BYPASS);

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      shift_q <= 10'h000;
      decode_q <= 10'h000;
    end else if (bit_edge) begin
      shift_q <= shift_d; // [RULE1]
      if (boundary) begin
        decode_q <= shift_d; // [RULE1]
      end
    end
  end

  // Free-running bit counter, realigned by the framer
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      bit_cnt_q <= `SRFD_BIT_FIRST; // [RULE24]
    end else if (boundary) begin
      bit_cnt_q <= `SRFD_BIT_FIRST; // [RULE2]
    end else if (bit_edge) begin
      bit_cnt_q <= 4'(bit_cnt_q + 4'h1);
    end
  end

  // ----------------------------------------
  // Decoder
  // ----------------------------------------
  always_comb begin
    d6 = dec6(decode_q[9:4]);
    c4 = (decode_q[9:4] == `SRFD_K28_POS6) ? ~decode_q[3:0] : decode_q[3:0];
    d4 = dec4(c4);
    b6 = blk(decode_q[9:4], 3'h3, rd_q); // [RULE23]
    b4 = blk({2'b00, decode_q[3:0]}, 3'h2, b6[0]);
    rd_d = b4[0]; // [RULE23]
    kx7 = d4[3] && (d6[4:0] == 5'd23 || d6[4:0] == 5'd27 || d6[4:0] == 5'd29 || d6[4:0] == 5'd30);
    dec_bad = !(d6[6] && d4[4]);
    dec_word.violation = 1'b0;
    dec_word.special = d6[5] | kx7; // [RULE6]
    dec_word.data = {d4[2:0], d6[4:0]}; // [RULE6] [RULE16]
    if (d6[5]) begin
      dec_word.data = {5'h00, d4[2:0]}; // [RULE17]
      if (d4[2:0] == 3'd7 && prev_k281_q) begin
        dec_word.data = `SRFD_CODE_C71; // [RULE18]
      end else if (d4[2:0] == 3'd7 && prev_k285_q) begin
        dec_word.data = `SRFD_CODE_C72; // [RULE18]
      end
    end else if (kx7) begin
      case (d6[4:0])
        5'd23: dec_word.data = `SRFD_CODE_K237;
        5'd27: dec_word.data = `SRFD_CODE_K277;
        5'd29: dec_word.data = `SRFD_CODE_K297;
        default: dec_word.data = `SRFD_CODE_K307;
      endcase
    end
    cur_k281 = !dec_bad && !b6[1] && !b4[1] && d6[5] && d4[2:0] == 3'd1;
    cur_k285 = !dec_bad && !b6[1] && !b4[1] && d6[5] && d4[2:0] == 3'd5;
    if (dec_bad) begin
      dec_word = '{violation: 1'b1, special: 1'b1, data: `SRFD_CODE_BAD}; // [RULE7] [RULE19]
    end else if (decode_q == `SRFD_K285_NEG && rd_q) begin
      dec_word = '{violation: 1'b1, special: 1'b1, data: `SRFD_CODE_K285_RDP}; // [RULE20]
    end else if (decode_q == `SRFD_K285_POS && !rd_q) begin
      dec_word = '{violation: 1'b1, special: 1'b1, data: `SRFD_CODE_K285_RDN}; // [RULE20]
    end else if (b6[1] || b4[1]) begin
      dec_word = '{violation: 1'b1, special: 1'b1, data: `SRFD_CODE_RD_ERR}; // [RULE21]
    end
  end

  // ----------------------------------------
  // Output register and disparity
  // ----------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      out_q <= '0;
      rd_q <= 1'b0;
      prev_k281_q <= 1'b0;
      prev_k285_q <= 1'b0;
    end else if (boundary) begin
      case (ctrl_q.mode)
        srfd_pkg::SRFD_BYPASS: begin
          out_q <= srfd_pkg::srfd_word_s'(decode_q); // [RULE8] [RULE22]
        end
        default: begin
          out_q <= dec_word; // [RULE5] [RULE10] [RULE22]
          rd_q <= rd_d; // [RULE23]
          prev_k281_q <= cur_k281;
          prev_k285_q <= cur_k285;
        end
      endcase
    end
  end

  assign raw_symbol_out = out_q;
  assign decoded_byte_out = out_q.data;
  assign special_char_flag_out = out_q.special;
  assign violation_flag_out = out_q.violation;

  // ----------------------------------------
  // Framing state and ready strobe
  // ----------------------------------------
  assign rf_rise = ctrl_q.rf & ~rf_prev_q;
  assign fill = is_comma(decode_q) && is_comma(shift_d); // [RULE13]

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      rf_prev_q <= 1'b0;
      await_q <= 1'b1; // [RULE24]
    end else begin
      rf_prev_q <= ctrl_q.rf;
      if (rf_rise) begin
        await_q <= 1'b1; // [RULE4]
      end else if (boundary && comma_hit) begin
        await_q <= 1'b0; // [RULE4]
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      rdy_arm_q <= 1'b0;
    end else if (rf_rise) begin
      rdy_arm_q <= 1'b0; // [RULE4]
    end else if (boundary) begin
      if (bypass) begin
        rdy_arm_q <= !await_q && is_comma(decode_q); // [RULE15]
      end else begin
        rdy_arm_q <= !await_q && !fill; // [RULE12] [RULE13] [RULE14]
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      ready_n_q <= 1'b1;
      byte_clk_q <= 1'b0;
    end else begin
      ready_n_q <= !(rdy_arm_q && bit_cnt_q < RDY_LOW_BITS); // [RULE11] [RULE10]
      byte_clk_q <= bit_cnt_q < `SRFD_BCLK_HIGH_BITS; // [RULE10]
    end
  end

  assign ready_n_out = ready_n_q;
  assign recovered_byte_clock_out = byte_clk_q;

  // ----------------------------------------
  // Wishbone slave
  // ----------------------------------------
  assign req = wb_cyc_in & wb_stb_in;

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q <= req & ~ack_q;
      if (req && !ack_q) begin
        rdata_q <= 32'h0000_0000;
        case (wb_adr_in)
          `SRFD_REG_CTRL: rdata_q[`SRFD_CTRL_MSB:0] <= ctrl_q;
          `SRFD_REG_STATUS: begin
            rdata_q[`SRFD_ST_AWAIT_BIT] <= await_q;
            rdata_q[`SRFD_ST_RD_BIT] <= rd_q;
            rdata_q[`SRFD_ST_WORD_MSB:`SRFD_ST_WORD_LSB] <= out_q;
          end
          default: rdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      ctrl_q <= srfd_pkg::srfd_ctrl_s'(`SRFD_CTRL_RST);
    end else if (req && wb_we_in && ack_q && wb_sel_in[0] && wb_adr_in == `SRFD_REG_CTRL) begin
      ctrl_q <= srfd_pkg::srfd_ctrl_s'(wb_dat_in[`SRFD_CTRL_MSB:0]); // [RULE3] [RULE22]
    end
  end

  assign wb_ack_out = ack_q;
  assign wb_dat_out = rdata_q;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  symbol_transfer_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // [RULE1]
    bit_edge && bit_cnt_q == `SRFD_BIT_LAST |=> bit_cnt_q == `SRFD_BIT_FIRST && decode_q == $past(shift_d))
    else $error("symbol not transferred after ten bits");
  comma_realign_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // [RULE2]
    bit_edge && ctrl_q.rf && is_comma(shift_d) |=> bit_cnt_q == `SRFD_BIT_FIRST && is_comma(decode_q))
    else $error("comma did not realign bit counter");
  frame_inhibit_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // [RULE3]
    bit_edge && !ctrl_q.rf && bit_cnt_q != `SRFD_BIT_LAST |=> bit_cnt_q == 4'($past(bit_cnt_q) + 4'h1))
    else $error("bit counter moved while framer inhibited");
  await_ready_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // [RULE4]
    await_q && !rf_rise |-> !rdy_arm_q ##1 ready_n_out)
    else $error("ready pulsed while awaiting framing");
  data_flow_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // [RULE5]
    boundary && await_q && !bypass |=> out_q == $past(dec_word))
    else $error("data stopped while awaiting framing");
  bypass_pass_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // [RULE8]
    boundary && bypass |=> raw_symbol_out == $past(decode_q))
    else $error("bypass symbol altered");
  ready_low_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // [RULE11]
    rdy_arm_q && bit_cnt_q < RDY_LOW_BITS |=> !ready_n_out)
    else $error("ready not low in first part of byte");
  fill_suppress_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // [RULE13]
    boundary && !bypass && fill |=> !rdy_arm_q ##1 ready_n_out)
    else $error("fill character produced ready");
  last_fill_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // [RULE14]
    boundary && !bypass && !await_q && !rf_rise && is_comma(decode_q) && !is_comma(shift_d) |=> rdy_arm_q)
    else $error("last comma of fill lost its ready");
  bypass_comma_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // [RULE15]
    boundary && bypass && !await_q && !rf_rise |=> rdy_arm_q == is_comma($past(decode_q)))
    else $error("bypass ready not tied to comma");
  unassigned_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // [RULE19]
    boundary && !bypass && dec_bad |=> violation_flag_out && special_char_flag_out &&
      decoded_byte_out == `SRFD_CODE_BAD)
    else $error("unassigned code not reported as E0");

endmodule

// ---- tb/srfd_tx_model.sv ----
// Remote serial transmitter model: bit clock, symbol queue and pad commas
`timescale 1ns/1ns
module srfd_tx_model (
  input wire logic clk_in, // System clock
  output logic bit_clk_out, // Bit clock, eight system clocks a bit
  output logic serial_out // Serial data, bit a first
);
  // 3ff asks for a comma of proper form, 3fe for one of wrong form
  logic [9:0] sym_q[$];
  logic [9:0] cur = 10'h0fa;
  logic [9:0] nxt;
  logic [2:0] div = 3'h0;
  logic [3:0] idx = 4'h9;
  logic rd_neg = 1'b1;
  // Set when the last wrong-form comma went out in its positive form
  logic wrong_pos = 1'b0;
  initial begin
    bit_clk_out = 1'b0;
    serial_out = 1'b0;
  end
  task automatic push(input logic [9:0] sym);
    sym_q.push_back(sym);
  endtask
  // ----------------------------------------
  // Serial data changes as the bit clock falls
  // ----------------------------------------
  always @(posedge clk_in) begin
    div <= div + 3'h1;
    if (div == 3'h7) begin
      bit_clk_out <= 1'b1;
    end
    if (div == 3'h3) begin
      bit_clk_out <= 1'b0;
      if (idx == 4'h9) begin
        idx = 4'h0;
        nxt = (sym_q.size() > 0) ? sym_q.pop_front() : 10'h3ff;
        if (nxt == 10'h3ff) begin
          cur = rd_neg ? 10'h0fa : 10'h305;
        end else if (nxt == 10'h3fe) begin
          cur = rd_neg ? 10'h305 : 10'h0fa;
          wrong_pos = rd_neg;
        end else begin
          cur = nxt;
        end
        if (cur == 10'h0fa) begin
          rd_neg = 1'b0;
        end else if (cur == 10'h305) begin
          rd_neg = 1'b1;
        end
      end else begin
        idx = idx + 4'h1;
      end
      serial_out <= cur[4'h9 - idx];
    end
  end
endmodule

// ---- tb/serial_rx_frame_decode_bench.sv ----
// Bench for the serial receive frame decoder
`timescale 1ns/1ns
module serial_rx_frame_decode_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] rd;
  logic ack, rdy_n, rdy_prev, bclk, ser, spec, viol, byte_clk;
  logic [9:0] held;
  logic [7:0] dbyte;
  logic [9:0] raw;
  logic [9:0] cap[$];
  logic [9:0] exp_w[7] = '{10'h105, 10'h0b5, 10'h04a, 10'h105, 10'h0b5, 10'h3e1, 10'h0b5};
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;
  int low_len = 0;
  initial begin
    forever #5 clk = ~clk;
  end
  srfd_tx_model i_tx (.clk_in(clk), .bit_clk_out(bclk), .serial_out(ser));
  srfd_rx i_dut (.sys_clk_in(clk), .sys_rst_in(rst), .rx_bit_clk_in(bclk), .rx_serial_in(ser),
    .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hf),
    .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack), .decoded_byte_out(dbyte),
    .special_char_flag_out(spec), .violation_flag_out(viol), .raw_symbol_out(raw),
    .ready_n_out(rdy_n), .recovered_byte_clock_out(byte_clk));
  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
    chk({31'h0, ack}, 32'h0);
  endtask
  // ----------------------------------------
  // Ready monitor: capture words, time low pulses
  // ----------------------------------------
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      fail_count++;
      report_and_stop();
    end
    if (!rst && rdy_prev === 1'b1 && rdy_n === 1'b0) begin
      cap.push_back(raw);
      held = raw;
      chk({31'h0, byte_clk}, 32'h1);
      low_len = 1;
    end else if (rdy_n === 1'b0) begin
      low_len++;
    end
    if (!rst && rdy_prev === 1'b0 && rdy_n === 1'b1) begin
      chk({viol, spec, dbyte}, held);
      chk(low_len, 48);
    end
    rdy_prev = rdy_n;
  end
  task automatic run_encoded();
    int n;
    cap.delete();
    repeat (300) @(posedge clk);
    chk(cap.size(), 0);
    foreach (exp_w[i]) begin
      i_tx.push((i == 0 || i == 3) ? 10'h3ff : (i == 5) ? 10'h3fe : (i == 2) ? 10'h155 : 10'h2aa);
    end
    n = 0;
    while (cap.size() < 7 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    chk(cap.size() >= 7, 1);
    foreach (exp_w[i]) begin
      if (i == 5) begin
        chk(cap[i], i_tx.wrong_pos ? 10'h3e2 : 10'h3e1);
      end else begin
        chk(cap[i], exp_w[i]);
      end
    end
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    wb(1'b0, 4'h0, 32'h0);
    chk(rd, 32'h4);
    wb(1'b0, 4'h4, 32'h0);
    chk(rd & 32'h1, 32'h1);
    wb(1'b0, 4'h8, 32'h0);
    chk(rd, 32'h0);
    run_encoded();
    wb(1'b1, 4'h4, 32'hffff);
    wb(1'b0, 4'h4, 32'h0);
    chk(rd & 32'h1, 32'h0);
    wb(1'b1, 4'h0, 32'h0);
    repeat (200) @(posedge clk);
    // Reframe on again, test mode decodes as encoded
    wb(1'b1, 4'h0, 32'h6);
    run_encoded();
    // Bypass with reframe on
    wb(1'b1, 4'h0, 32'h5);
    repeat (300) @(posedge clk);
    cap.delete();
    i_tx.push(10'h2aa);
    i_tx.push(10'h155);
    repeat (1600) @(posedge clk);
    chk(cap.size() > 2, 1);
    foreach (cap[i]) begin
      chk(cap[i] === 10'h0fa || cap[i] === 10'h305, 1);
    end
    report_and_stop();
  end
endmodule
